// *** core/tmr_pkg.sv ***
package tmr_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00; // enables, modes
    localparam logic [7:0] ADDR_PRE_W   = 8'h04; // wide prescaler
    localparam logic [7:0] ADDR_PER_W   = 8'h08; // wide period
    localparam logic [7:0] ADDR_CNT_W   = 8'h0c; // wide counter (ro)
    localparam logic [7:0] ADDR_CH_BASE = 8'h10; // 5 channel words
    localparam logic [7:0] ADDR_NCFG0   = 8'h30; // narrow 0 config
    localparam logic [7:0] ADDR_NCFG1   = 8'h34; // narrow 1 config
    localparam logic [7:0] ADDR_NCNT    = 8'h38; // narrow counters (ro)
    localparam logic [7:0] ADDR_STAT    = 8'h3c; // sticky events, w1c
    localparam logic [7:0] ADDR_MASK    = 8'h40; // interrupt mask
    localparam logic [7:0] ADDR_OUTS    = 8'h44; // pin levels (ro)

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_WIDE_EN  = 0;  // wide timer run
    localparam int CTRL_N0_EN    = 1;  // narrow 0 run
    localparam int CTRL_N1_EN    = 2;  // narrow 1 run
    localparam int CTRL_IR_MODE  = 3;  // ir generation select
    localparam int CTRL_CAP_LSB  = 8;  // 5 bits: channel is capture
    localparam int CTRL_EDGE_LSB = 16; // 5x2 bits: rise, fall
    localparam int CTRL_IRCH_LSB = 28; // 3 bits: ir channel select
    localparam int NCFG_PER_LSB  = 8;  // narrow period field
    localparam int NCFG_CMP_LSB  = 16; // narrow compare field
    localparam int STAT_OVF_W    = 0;  // wide overflow flag
    localparam int STAT_OVF_N0   = 1;  // narrow 0 overflow flag
    localparam int STAT_OVF_N1   = 2;  // narrow 1 overflow flag
    localparam int STAT_CAP_LSB  = 3;  // 5 capture flags

    // ----------------------------------------------------------------
    // reset values and sizes
    // ----------------------------------------------------------------
    localparam int          NUM_CH      = 5;
    localparam int          STAT_W      = 8;
    localparam logic [15:0] RST_PER_W   = 16'hffff;
    localparam logic [7:0]  RST_PER_N   = 8'hff;
    localparam logic [31:0] RST_CTRL    = 32'h0000_0000;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_s;

endpackage

// *** core/tmr_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser with edge detect on the settled copy
module tmr_sync
    import tmr_pkg::*;
#(
    parameter int W = 5
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] s1;  // first stage, read only by s2
        logic [W-1:0] s2;  // settled level
        logic [W-1:0] s3;  // previous settled level
    } st_s;

    st_s st;
    st_s next_st;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // edges seen only from settled stages
    assign rise = st.s2 & ~st.s3;
    assign fall = ~st.s2 & st.s3;
endmodule

// *** core/tmr_narrow.sv ***
`timescale 1ns/1ps
// 8-bit timer with prescaler, period and one pwm channel
module tmr_narrow
    import tmr_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    input  wire logic [7:0]   pre,
    input  wire logic [W-1:0] per,
    input  wire logic [W-1:0] cmp,
    output logic      [W-1:0] cnt,
    output logic              wrap,
    output logic              pwm
);
    typedef struct packed {
        logic [7:0]   pc;   // prescale count
        logic [W-1:0] cnt;  // main count
        logic         wrap; // period done pulse
        logic         pwm;  // output level
    } st_s;

    st_s  st;
    st_s  next_st;
    logic tick;

    assign tick = en && (st.pc >= pre);

    // ----------------------------------------------------------------
    // counting
    // ----------------------------------------------------------------
    always_comb begin
        next_st      = st;
        next_st.wrap = 1'b0;
        if (!en) begin
            next_st.pc = 8'h00;
        end else if (tick) begin
            next_st.pc = 8'h00;
            if (st.cnt >= per) begin
                next_st.cnt  = '0;
                next_st.wrap = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end else begin
            next_st.pc = st.pc + 8'h01;
        end
        // high while below compare, low to end of period
        next_st.pwm = en && (next_st.cnt < cmp);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cnt  = st.cnt;
    assign wrap = st.wrap;
    assign pwm  = st.pwm;
endmodule

// *** core/tmr_group.sv ***
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - wide 16-bit up counter, prescaler, period
// - five channels each with 16-bit compare
// - channel is pwm output or edge capture
// - ir mode counts first narrow timer periods
// - ir output is wide channel and narrow
// - narrow timers 8-bit, own prescaler, period
// - each narrow timer has one compare
// - narrow channel drives pwm waveform
// - capture inputs synchronised, pulses 1.5 clocks
module tmr_group
    import tmr_pkg::*;
#(
    parameter int CW = 16, // wide counter width
    parameter int NW = 8   // narrow counter width
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [NUM_CH-1:0] cap_in,
    output logic      [NUM_CH-1:0] wide_pwm,
    output logic                   narrow0_pwm,
    output logic                   narrow1_pwm,
    output logic                   ir_out,
    output logic                   irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0]             ctrl;  // enables and modes
        logic [15:0]             pre_w; // wide prescale divisor-1
        logic [CW-1:0]           per_w; // wide period
        logic [15:0]             pc_w;  // wide prescale count
        logic [CW-1:0]           cnt_w; // wide counter
        logic [NUM_CH-1:0][CW-1:0] cc;  // compare / capture values
        logic [NUM_CH-1:0]       pwm;   // wide channel outputs
        logic [31:0]             ncfg0; // narrow 0 config
        logic [31:0]             ncfg1; // narrow 1 config
        logic [STAT_W-1:0]       stat;  // sticky events
        logic [STAT_W-1:0]       mask;  // interrupt mask
        logic                    ack;   // bus answer
        logic [31:0]             rdat;  // read data
        logic                    ir;    // modulated output
    } st_s;

    st_s st;
    st_s next_st;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // byte-lane merge for register writes
    function automatic logic [31:0] lane_wr(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // channel index for a channel word address, NUM_CH when none
    function automatic logic [2:0] ch_idx(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h5;
        for (int i = 0; i < NUM_CH; i++) begin
            if (a == ADDR_CH_BASE + 8'(i * 4)) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // narrow timers
    // ----------------------------------------------------------------
    logic [NW-1:0] n0_cnt;
    logic [NW-1:0] n1_cnt;
    logic          n0_wrap;
    logic          n1_wrap;
    logic          n0_pwm;
    logic          n1_pwm;

    tmr_narrow #(.W(NW)) u_n0 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .en       (st.ctrl[CTRL_N0_EN]),
        .pre      (st.ncfg0[7:0]),
        .per      (st.ncfg0[NCFG_PER_LSB +: NW]),
        .cmp      (st.ncfg0[NCFG_CMP_LSB +: NW]),
        .cnt      (n0_cnt),
        .wrap     (n0_wrap),
        .pwm      (n0_pwm)
    );

    tmr_narrow #(.W(NW)) u_n1 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .en       (st.ctrl[CTRL_N1_EN]),
        .pre      (st.ncfg1[7:0]),
        .per      (st.ncfg1[NCFG_PER_LSB +: NW]),
        .cmp      (st.ncfg1[NCFG_CMP_LSB +: NW]),
        .cnt      (n1_cnt),
        .wrap     (n1_wrap),
        .pwm      (n1_pwm)
    );

    // ----------------------------------------------------------------
    // capture input synchronisers
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] cap_rise;
    logic [NUM_CH-1:0] cap_fall;

    // two flops at core rate; a pulse must span one sample edge
    tmr_sync #(.W(NUM_CH)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      (cap_in),
        .rise     (cap_rise),
        .fall     (cap_fall)
    );

    // ----------------------------------------------------------------
    // main next-state logic
    // ----------------------------------------------------------------
    logic              wide_tick;
    logic              wide_wrap;
    logic [NUM_CH-1:0] cap_ev;
    logic [STAT_W-1:0] ev;
    logic              wr;
    logic              rd;
    logic [2:0]        ci;
    logic [2:0]        irch;

    always_comb begin
        next_st = st;
        ci      = ch_idx(wb_adr_i);
        irch    = st.ctrl[CTRL_IRCH_LSB +: 3];
        wr      = wb_cyc_i && wb_stb_i && !st.ack && wb_we_i;
        rd      = wb_cyc_i && wb_stb_i && !st.ack && !wb_we_i;

        // tick source: prescaler, or narrow 0 periods in ir mode
        wide_tick = 1'b0;
        if (!st.ctrl[CTRL_WIDE_EN]) begin
            next_st.pc_w = 16'h0000;
        end else if (st.ctrl[CTRL_IR_MODE]) begin
            wide_tick    = n0_wrap;
            next_st.pc_w = 16'h0000;
        end else if (st.pc_w >= st.pre_w) begin
            wide_tick    = 1'b1;
            next_st.pc_w = 16'h0000;
        end else begin
            next_st.pc_w = st.pc_w + 16'h0001;
        end

        // wide counter with wrap at the period value
        wide_wrap = wide_tick && (st.cnt_w >= st.per_w);
        if (wide_wrap) begin
            next_st.cnt_w = '0;
        end else if (wide_tick) begin
            next_st.cnt_w = st.cnt_w + 1'b1;
        end

        // channels: compare drives pwm, capture latches counter
        cap_ev = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (st.ctrl[CTRL_CAP_LSB + i]) begin
                next_st.pwm[i] = 1'b0;
                cap_ev[i] = (cap_rise[i] && st.ctrl[CTRL_EDGE_LSB + 2*i])
                    || (cap_fall[i] && st.ctrl[CTRL_EDGE_LSB + 2*i + 1]);
                if (cap_ev[i]) begin
                    next_st.cc[i] = st.cnt_w;
                end
            end else begin
                // high below compare, low from match to wrap
                next_st.pwm[i] = st.ctrl[CTRL_WIDE_EN]
                                 && (next_st.cnt_w < st.cc[i]);
            end
        end

        // ir carrier gate on the selected wide channel
        next_st.ir = st.ctrl[CTRL_IR_MODE] && (irch < 3'h5)
                     && st.pwm[irch] && n0_pwm;

        // events, gathered for the sticky register
        ev = '0;
        ev[STAT_OVF_W]  = wide_wrap;
        ev[STAT_OVF_N0] = n0_wrap;
        ev[STAT_OVF_N1] = n1_wrap;
        ev[STAT_CAP_LSB +: NUM_CH] = cap_ev;

        // bus writes; a new event wins over a one-to-clear
        next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
        next_st.stat = st.stat | ev;
        if (wr) begin
            case (wb_adr_i)
                ADDR_CTRL:  next_st.ctrl  = lane_wr(st.ctrl, wb_dat_i,
                                                    wb_sel_i);
                ADDR_PRE_W: next_st.pre_w = 16'(lane_wr({16'h0, st.pre_w},
                                                 wb_dat_i, wb_sel_i));
                ADDR_PER_W: next_st.per_w = CW'(lane_wr(32'(st.per_w),
                                                 wb_dat_i, wb_sel_i));
                ADDR_NCFG0: next_st.ncfg0 = lane_wr(st.ncfg0, wb_dat_i,
                                                    wb_sel_i);
                ADDR_NCFG1: next_st.ncfg1 = lane_wr(st.ncfg1, wb_dat_i,
                                                    wb_sel_i);
                ADDR_STAT: begin
                    if (wb_sel_i[0]) begin
                        next_st.stat = (st.stat & ~wb_dat_i[STAT_W-1:0])
                                       | ev;
                    end
                end
                ADDR_MASK: begin
                    if (wb_sel_i[0]) begin
                        next_st.mask = wb_dat_i[STAT_W-1:0];
                    end
                end
                default: begin
                    // channel words; capture still wins the same cycle
                    if (ci < 3'h5 && !cap_ev[ci]) begin
                        next_st.cc[ci] = CW'(lane_wr(32'(st.cc[ci]),
                                             wb_dat_i, wb_sel_i));
                    end
                end
            endcase
        end

        // bus reads; unmapped words read zero
        next_st.rdat = 32'h0000_0000;
        if (rd) begin
            case (wb_adr_i)
                ADDR_CTRL:  next_st.rdat = st.ctrl;
                ADDR_PRE_W: next_st.rdat = {16'h0000, st.pre_w};
                ADDR_PER_W: next_st.rdat = 32'(st.per_w);
                ADDR_CNT_W: next_st.rdat = 32'(st.cnt_w);
                ADDR_NCFG0: next_st.rdat = st.ncfg0;
                ADDR_NCFG1: next_st.rdat = st.ncfg1;
                ADDR_NCNT:  next_st.rdat = {16'h0000, 8'(n1_cnt),
                                            8'(n0_cnt)};
                ADDR_STAT:  next_st.rdat = 32'(st.stat);
                ADDR_MASK:  next_st.rdat = 32'(st.mask);
                ADDR_OUTS:  next_st.rdat = {24'h0, n1_pwm, n0_pwm, st.ir,
                                            st.pwm};
                default: begin
                    if (ci < 3'h5) begin
                        next_st.rdat = 32'(st.cc[ci]);
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st       <= '0;
            st.ctrl  <= RST_CTRL;
            st.per_w <= RST_PER_W;
            st.ncfg0 <= {8'h00, 8'h00, RST_PER_N, 8'h00};
            st.ncfg1 <= {8'h00, 8'h00, RST_PER_N, 8'h00};
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_ack_o    = st.ack;
    assign wb_dat_o    = st.rdat;
    assign wide_pwm    = st.pwm;
    assign narrow0_pwm = n0_pwm;
    assign narrow1_pwm = n1_pwm;
    assign ir_out      = st.ir;
    // level, high while any unmasked sticky bit is set
    assign irq         = |(st.stat & st.mask);
endmodule

// *** tb/tmr_group_sva.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the timer group
// ----------------------------------------------------------------
module tmr_group_chk
    import tmr_pkg::*;
#(
    parameter int CW = 16, // wide counter width
    parameter int NW = 8   // narrow counter width
) (
    input wire logic              core_clk,
    input wire logic              rst_n,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [NUM_CH-1:0] cap_in,
    input wire logic [NUM_CH-1:0] wide_pwm,
    input wire logic              narrow0_pwm,
    input wire logic              narrow1_pwm,
    input wire logic              ir_out,
    input wire logic              irq
);
    logic       req;       // live request on the bus
    logic [7:0] mask_copy; // shadow of the interrupt mask

    assign req = wb_cyc_i && wb_stb_i;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // mask shadow moves on the take edge, in step with the register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mask_copy <= 8'h00;
        end else if (req && !wb_ack_o && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == ADDR_MASK) begin
            mask_copy <= wb_dat_i[7:0];
        end
    end

    a_ack_pulse:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_prompt:
        assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_cause:
        assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack without request");
    a_data_idle:
        assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_reset_quiet:
        assert property ($rose(rst_n) |-> !irq && !wb_ack_o && !ir_out
                         && wide_pwm == 5'h00 && !narrow0_pwm
                         && !narrow1_pwm)
        else $error("outputs not low after reset");
    a_void_read:
        assert property (req && wb_ack_o && !wb_we_i
                         && wb_adr_i == 8'h48 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_mask_back:
        assert property (req && wb_ack_o && !wb_we_i
                         && wb_adr_i == ADDR_MASK
                         |-> wb_dat_o[7:0] == mask_copy)
        else $error("mask readback differs from last write");
    a_irq_masked:
        assert property (mask_copy == 8'h00 && $past(mask_copy == 8'h00)
                         |-> !irq)
        else $error("irq high with mask clear");
    a_ir_gated:
        assert property (ir_out |-> (narrow0_pwm || $past(narrow0_pwm))
                         && (|wide_pwm || $past(|wide_pwm)))
        else $error("ir high without both sources");

    // main scenarios reached
    c_write: cover property (req && wb_ack_o && wb_we_i);
    c_irq:   cover property ($rose(irq));
    c_ir:    cover property ($rose(ir_out));
    c_n1:    cover property ($rose(narrow1_pwm));
endmodule

bind tmr_group tmr_group_chk #(.CW(CW), .NW(NW)) chk_u (
    .core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cap_in, .wide_pwm,
    .narrow0_pwm, .narrow1_pwm, .ir_out, .irq
);

// *** tb/pin_model.sv ***
`timescale 1ns/1ps
// pin side: capture sources and counting pwm loads
module pin_model (
    input  wire logic        core_clk,
    input  wire logic [7:0]  loads,  // wide[4:0], ir, n0, n1
    input  wire logic        clr,    // restart load counters
    input  wire logic [4:0]  fire,   // capture pulse request
    output logic      [4:0]  cap_in,
    output logic [7:0][15:0] hits
);
    logic [1:0] hold; // edges left in the pulse

    initial begin
        cap_in = 5'h00;
        hold   = 2'd0;
    end

    // pulse stays up two edges so the synchroniser sees it
    always @(posedge core_clk) begin
        if (fire != 5'h00) begin
            cap_in <= fire;
            hold   <= 2'd2;
        end else if (hold != 2'd0) begin
            hold <= hold - 2'd1;
            if (hold == 2'd1) begin
                cap_in <= 5'h00;
            end
        end
    end

    // cycles seen high per load line
    always @(posedge core_clk) begin
        for (int i = 0; i < 8; i++) begin
            hits[i] <= clr ? 16'h0 : hits[i] + 16'(loads[i]);
        end
    end
endmodule

// *** tb/tmr_group_tb.sv ***
`timescale 1ns/1ps
module tmr_group_tb
    import tmr_pkg::*;
;
    logic              core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0]        wb_adr_i;
    logic [3:0]        wb_sel_i;
    logic [31:0]       wb_dat_i, wb_dat_o, q, cnt;
    logic              wb_ack_o, narrow0_pwm, narrow1_pwm, ir_out, irq;
    logic [4:0]        cap_in, wide_pwm, fire;
    logic              clr;
    logic [7:0][15:0]  hits;
    int                failures, checks;
    logic [31:0] cmp_tab [NUM_CH] = '{32'h0, 32'h3, 32'h5, 32'h8, 32'ha};
    logic [31:0] pwm_exp [NUM_CH] = '{32'd0, 32'd60, 32'd100, 32'd160,
                                      32'd200};

    tmr_group dut_u (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cap_in,
        .wide_pwm, .narrow0_pwm, .narrow1_pwm, .ir_out, .irq);
    pin_model pins_u (.core_clk, .clr, .fire, .cap_in, .hits,
        .loads({narrow1_pwm, narrow0_pwm, ir_out, wide_pwm}));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one classic cycle; waits for ack, bounded
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        if (n >= 20) failures++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rdc(input string what, input logic [7:0] a,
             input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(what, q, exp);
    endtask

    // count load highs over n cycles
    task measure(input int n);
        @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        repeat (n + 1) @(posedge core_clk);
    endtask

    task settle;
        repeat (2) @(posedge core_clk);
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, clr} = 4'h0;
        {wb_adr_i, wb_dat_i, fire} = '0;
        wb_sel_i = 4'hf;
        rst_n = 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rdc("ctrl", ADDR_CTRL, RST_CTRL);
        rdc("period", ADDR_PER_W, {16'h0, RST_PER_W});
        rdc("ncfg0", ADDR_NCFG0, {16'h0, RST_PER_N, 8'h0});
        rdc("ncfg1", ADDR_NCFG1, {16'h0, RST_PER_N, 8'h0});
        rdc("unmapped", 8'h48, 32'h0);
        rdc("outs", ADDR_OUTS, 32'h0);
        rdc("ncnt", ADDR_NCNT, 32'h0);
        // five wide channels, tick every 2 clocks, period 10
        wr(ADDR_PRE_W, 32'h1);
        wr(ADDR_PER_W, 32'h9);
        for (int i = 0; i < NUM_CH; i++) begin
            wr(ADDR_CH_BASE + 8'(4 * i), cmp_tab[i]);
        end
        wr(ADDR_CTRL, 32'h1);
        measure(200);
        for (int i = 0; i < NUM_CH; i++) begin
            check("wide pwm", {16'h0, hits[i]}, pwm_exp[i]);
        end
        rdc("wide wrap", ADDR_STAT, 32'h1);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_STAT, 32'hff);
        // both narrow timers, differing prescale
        wr(ADDR_NCFG0, 32'h0002_0300);
        wr(ADDR_NCFG1, 32'h0003_0701);
        wr(ADDR_CTRL, 32'h6);
        measure(160);
        check("narrow0", {16'h0, hits[6]}, 32'd80);
        check("narrow1", {16'h0, hits[7]}, 32'd60);
        wr(ADDR_CTRL, 32'h0);
        rdc("narrow wrap", ADDR_STAT, 32'h6);
        wr(ADDR_MASK, 32'h2);
        settle;
        check("irq on", {31'h0, irq}, 32'h1);
        wr(ADDR_STAT, 32'h2);
        rdc("w1c", ADDR_STAT, 32'h4);
        settle;
        check("irq off", {31'h0, irq}, 32'h0);
        wr(ADDR_MASK, 32'h4);
        rdc("mask", ADDR_MASK, 32'h4);
        settle;
        check("irq other", {31'h0, irq}, 32'h1);
        wr(ADDR_MASK, 32'h0);
        // ir mode: wide steps per narrow0 wrap
        wr(ADDR_STAT, 32'hff);
        wr(ADDR_PRE_W, 32'h0);
        wr(ADDR_CH_BASE, 32'h5);
        wr(ADDR_CTRL, 32'h0000_000b);
        measure(400);
        check("ir wide", {16'h0, hits[0]}, 32'd200);
        check("ir out", {16'h0, hits[5]}, 32'd100);
        wr(ADDR_CTRL, 32'h4000_000b);
        measure(400);
        check("ir ch4", {16'h0, hits[5]}, 32'd200);
        // capture after a reset in mid-run: ch3 rise, ch4 fall
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        wr(ADDR_CTRL, 32'h0240_1801);
        wr(ADDR_CTRL, 32'h0240_1800);
        xfer(1'b0, ADDR_CNT_W, 32'h0);
        cnt = q;
        @(posedge core_clk);
        fire <= 5'h18;
        @(posedge core_clk);
        fire <= 5'h00;
        repeat (10) @(posedge core_clk);
        rdc("cap flags", ADDR_STAT, 32'h0000_00c0);
        rdc("cap ch3", ADDR_CH_BASE + 8'h0c, cnt);
        rdc("cap ch4", ADDR_CH_BASE + 8'h10, cnt);
        check("cap pins", {30'h0, wide_pwm[4:3]}, 32'h0);
        stop_test;
    end

    // hang guard, far beyond the sequence length
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        stop_test;
    end
endmodule
